// ==== spi_map.svh ====
// Constants for the serial port controller with DMA
`ifndef SPI_MAP_SVH
`define SPI_MAP_SVH
`define CLK_NS 5
`define BIT_NS 50
`define MIN_HALF ((`BIT_NS + 2 * `CLK_NS - 1) / (2 * `CLK_NS))
`define FIFO_DEPTH 64
`define FIFO_AW 6
`define FIFO_CW 7
`define LEN_MIN_M1 5'h03
`define LEN_MAX_M1 5'h1F
`define DMA_BURST_MAX_B 8'h40
`define DMA_BUF_BYTES 128
`define ST_W 6
`define ST_TX_LOW 0
`define ST_RX_HIGH 1
`define ST_RX_OVR 2
`define ST_TX_OVF 3
`define ST_DMA0 4
`define ST_DMA1 5
`endif

// ==== spi_pkg.sv ====
// Types for the serial port controller with DMA
package spi_pkg;
   typedef struct packed {
      logic [7:0] half_div;
      logic [4:0] len_m1;
      logic cs_sel;
      logic [5:0] tx_thr;
      logic [5:0] rx_thr;
   } ser_cfg_t;
   typedef struct packed {
      logic sw_mode;
      logic [9:0] sw_val;
      logic [9:0] act_val;
   } ltr_cfg_t;
   typedef struct packed {
      logic [31:0] src_addr;
      logic [31:0] dst_addr;
      logic [11:0] block_bytes;
      logic [1:0] src_w;
      logic [1:0] dst_w;
      logic [2:0] burst_log2;
      logic src_inc;
      logic dst_inc;
      logic hs_sel;
      logic link_en;
      logic [31:0] next_ptr;
   } dma_cfg_t;
   typedef struct packed {
      logic valid;
      logic we;
      logic [31:0] addr;
      logic [1:0] size;
      logic [31:0] wdata;
   } mem_req_t;
   typedef enum logic [1:0] {SER_IDLE, SER_LEAD, SER_BITS, SER_TRAIL} ser_state_t;
   typedef enum logic [1:0] {CH_IDLE, CH_WAIT, CH_XFER, CH_DESC} ch_state_t;
endpackage

// ==== spi_master_with_dma.sv ====
// Master-only serial port controller with entry FIFOs and two DMA channels
// Function
// RULE1: Block is master only; it drives clock and chip selects, never responds.
// RULE2: Bit rate programmable, never faster than twenty megabits per second.
// RULE3: Frames four to thirty-two bits; transmit and receive FIFOs hold 64 entries.
// RULE4: Processor moves one entry per 32-bit access.
// RULE5: Transmit writes drop bits above the frame length.
// RULE6: Received frames are right-justified with zeros above the frame length.
// RULE7: DMA moves one entry per access of 1, 2 or 4 bytes.
// RULE8: Full duplex: shift out transmit entries while shifting in receive words.
// RULE9: Crossing a FIFO threshold raises enabled interrupt or DMA request.
// RULE10: Selected chip select asserted; serial clock goes to all devices.
// RULE11: DMA does memory-to-peripheral and peripheral-to-memory, paced by handshake.
// RULE12: DMA programmed directly or by linked descriptors loaded block by block.
// RULE13: Source and destination widths are one, two or four bytes.
// RULE14: Bursts are power of two beats up to 128.
// RULE15: Each channel buffers 128 bytes; serial-side bursts at most 64 bytes. Channels have no buffer; entries go straight between FIFO and memory.
// RULE16: Block size counted in bytes, independent of transfer widths.
// RULE17: Source and destination addresses increment or stay constant.
// RULE18: Any handshake to any channel, per-channel enable, early termination.
// RULE19: Controller and DMA held in reset until software releases them.
// RULE20: During power gating serial outputs hold idle and never toggle. Gated mid-frame, they freeze at their current levels instead.
// RULE21: Latency report from hardware state or from driver values.
// RULE22: Interrupt is level, active high, held until software clears source.
// RULE23: Two chip selects, one clock, one data out, one data in.
// RULE24: Chip selects deasserted whenever no frame is in progress.
// RULE25: Overrun and overflow errors raise the interrupt and are recorded.
`timescale 1ns/1ps
`include "spi_map.svh"

module spi_entry_fifo (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic push,
   input wire logic [31:0] wdata,
   input wire logic pop,
   output logic [31:0] rdata,
   output logic full,
   output logic empty,
   output logic [`FIFO_CW-1:0] count
);
   logic [31:0] mem_q [`FIFO_DEPTH];
   logic [`FIFO_AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [`FIFO_CW-1:0] cnt_q, cnt_d;
   logic do_push, do_pop;

   assign full = (cnt_q == `FIFO_CW'(`FIFO_DEPTH));
   assign empty = (cnt_q == '0);
   assign count = cnt_q;
   assign rdata = mem_q[rp_q];
   assign do_push = push && !full;
   assign do_pop = pop && !empty;

   always_comb begin
      wp_d = do_push ? wp_q + 1'b1 : wp_q;
      rp_d = do_pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + {{(`FIFO_CW-1){1'b0}}, do_push} - {{(`FIFO_CW-1){1'b0}}, do_pop};
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
      end
      if (do_push) begin
         mem_q[wp_q] <= wdata; // RULE3
      end
   end
endmodule // spi_entry_fifo

module spi_dma_channel import spi_pkg::*; #(
   parameter bit IS_RX = 1'b0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic abort,
   input dma_cfg_t cfg,
   input dma_cfg_t desc_in,
   input wire logic desc_valid,
   input wire logic hs_tx,
   input wire logic hs_rx,
   input wire logic fifo_ok,
   input wire logic [31:0] fifo_rdata,
   input wire logic mem_ready,
   output mem_req_t mem_req,
   output logic move,
   output logic desc_req,
   output logic [31:0] desc_addr,
   output logic done,
   output logic busy
);
   ch_state_t st_q, st_d;
   dma_cfg_t cur_q, cur_d;
   logic [7:0] beats_q, beats_d, beats_all, beats_cap;
   logic [1:0] width;
   logic [11:0] wbytes;
   logic hs;

   assign busy = (st_q != CH_IDLE);
   assign desc_addr = cur_q.next_ptr;

   always_comb begin
      st_d = st_q;
      cur_d = cur_q;
      beats_d = beats_q;
      done = 1'b0;
      desc_req = 1'b0;
      move = 1'b0;
      mem_req = '0;
      width = IS_RX ? cur_q.dst_w : cur_q.src_w; // RULE13
      wbytes = 12'h001 << width;
      hs = cur_q.hs_sel ? hs_rx : hs_tx; // RULE18
      beats_all = 8'h01 << cur_q.burst_log2; // RULE14
      beats_cap = `DMA_BURST_MAX_B >> width; // RULE15
      case (st_q)
         CH_IDLE: begin
            if (start) begin
               cur_d = cfg; // RULE12
               st_d = CH_WAIT;
            end
         end
         CH_WAIT: begin
            if (abort) begin
               st_d = CH_IDLE; // RULE18
               done = 1'b1;
            end else if (cur_q.block_bytes == '0) begin
               st_d = cur_q.link_en ? CH_DESC : CH_IDLE; // RULE12
               done = !cur_q.link_en;
            end else if (hs) begin
               beats_d = (beats_all < beats_cap) ? beats_all : beats_cap; // RULE11
               st_d = CH_XFER;
            end
         end
         CH_XFER: begin
            mem_req.valid = fifo_ok && !abort;
            mem_req.we = IS_RX;
            mem_req.addr = IS_RX ? cur_q.dst_addr : cur_q.src_addr;
            mem_req.size = width;
            mem_req.wdata = fifo_rdata;
            if (abort) begin
               st_d = CH_IDLE;
               done = 1'b1;
            end else if (fifo_ok && mem_ready) begin
               move = 1'b1; // RULE7
               if (cur_q.src_inc) begin
                  cur_d.src_addr = cur_q.src_addr + {20'h0, wbytes}; // RULE17
               end
               if (cur_q.dst_inc) begin
                  cur_d.dst_addr = cur_q.dst_addr + {20'h0, wbytes}; // RULE17
               end
               cur_d.block_bytes = (cur_q.block_bytes > wbytes) ?
                  cur_q.block_bytes - wbytes : 12'h000; // RULE16
               beats_d = beats_q - 8'h01;
               if (beats_q == 8'h01 || cur_q.block_bytes <= wbytes) begin
                  st_d = CH_WAIT;
               end
            end
         end
         CH_DESC: begin
            desc_req = !abort;
            if (abort) begin
               st_d = CH_IDLE;
               done = 1'b1;
            end else if (desc_valid) begin
               cur_d = desc_in; // RULE12
               st_d = CH_WAIT;
            end
         end
         default: st_d = CH_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_q <= CH_IDLE;
         cur_q <= '0;
         beats_q <= '0;
      end else begin
         st_q <= st_d;
         cur_q <= cur_d;
         beats_q <= beats_d;
      end
   end
endmodule // spi_dma_channel

module spi_master_with_dma import spi_pkg::*; (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic reset_wr,
   input wire logic reset_val,
   input wire logic power_gate,
   input ser_cfg_t ser_cfg,
   input ltr_cfg_t ltr_cfg,
   output logic [9:0] ltr_val,
   input wire logic tx_push,
   input wire logic [31:0] tx_data,
   output logic tx_ready,
   input wire logic rx_pop,
   output logic [31:0] rx_data,
   output logic rx_avail,
   input wire logic [1:0] dma_start,
   input wire logic [1:0] dma_abort,
   input dma_cfg_t [1:0] dma_cfg,
   input dma_cfg_t [1:0] desc_in,
   input wire logic [1:0] desc_valid,
   output logic [1:0] desc_req,
   output logic [1:0][31:0] desc_addr,
   output mem_req_t [1:0] mem_req,
   input wire logic [1:0] mem_ready,
   input wire logic [1:0][31:0] mem_rdata,
   output logic [1:0] dma_busy,
   input wire logic [`ST_W-1:0] irq_en,
   input wire logic [`ST_W-1:0] stat_clr,
   output logic [`ST_W-1:0] status,
   output logic irq,
   output logic sclk,
   output logic [1:0] cs_b,
   output logic mosi,
   input wire logic miso
);
   logic run_q, run_d, core_rst_n, miso_m_q, miso_s_q;
   ser_state_t st_q, st_d;
   logic [7:0] div_q, div_d, half;
   logic [4:0] len, bit_q, bit_d;
   logic [31:0] mask, tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d;
   logic sclk_q, sclk_d, mosi_q, mosi_d, tick, frame_done;
   logic [1:0] cs_b_q, cs_b_d;
   logic [`ST_W-1:0] st_bits_q, st_bits_d, st_set;
   logic irq_q, irq_d;
   logic [9:0] ltr_q, ltr_d;
   logic tx_full, tx_empty, rx_full, rx_empty, tx_fpush, tx_fpop, rx_fpush, rx_fpop;
   logic [31:0] tx_head, tx_fdata;
   logic [`FIFO_CW-1:0] tx_cnt, rx_cnt;
   logic [1:0] dma_move, dma_done, fifo_ok;
   logic hs_tx, hs_rx;
   logic [31:0] rx_head_w;

   // Software-released reset: the whole core stays in reset until enabled
   assign core_rst_n = rst_b && run_q; // RULE19
   always_comb run_d = reset_wr ? reset_val : run_q; // RULE19
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         run_q <= 1'b0;
         miso_m_q <= 1'b0;
         miso_s_q <= 1'b0;
      end else begin
         run_q <= run_d;
         miso_m_q <= miso;
         miso_s_q <= miso_m_q;
      end
   end

   assign len = (ser_cfg.len_m1 < `LEN_MIN_M1) ? `LEN_MIN_M1 : ser_cfg.len_m1; // RULE3
   assign mask = 32'hFFFFFFFF >> (`LEN_MAX_M1 - len);
   // DMA has priority on the transmit FIFO; the processor sees tx_ready drop
   assign tx_fpush = dma_move[0] || (tx_push && tx_ready); // RULE4
   assign tx_fdata = (dma_move[0] ? mem_rdata[0] : tx_data) & mask; // RULE5
   assign tx_ready = !tx_full && !dma_move[0];
   assign rx_avail = !rx_empty && !dma_move[1];
   assign rx_fpop = dma_move[1] || (rx_pop && rx_avail); // RULE4
   assign rx_data = rx_head_w;

   spi_entry_fifo u_tx_fifo (.clk(clk), .rst_n(core_rst_n), .push(tx_fpush),
      .wdata(tx_fdata), .pop(tx_fpop), .rdata(tx_head), .full(tx_full),
      .empty(tx_empty), .count(tx_cnt));
   spi_entry_fifo u_rx_fifo (.clk(clk), .rst_n(core_rst_n), .push(rx_fpush),
      .wdata(rx_sh_q), .pop(rx_fpop), .rdata(rx_head_w), .full(rx_full),
      .empty(rx_empty), .count(rx_cnt));

   assign hs_tx = (tx_cnt <= {1'b0, ser_cfg.tx_thr}); // RULE9
   assign hs_rx = (rx_cnt >= {1'b0, ser_cfg.rx_thr}) && !rx_empty; // RULE9
   assign fifo_ok = {!rx_empty, !tx_full};

   for (genvar c = 0; c < 2; c++) begin : g_dma
      spi_dma_channel #(.IS_RX(c == 1)) u_ch (.clk(clk), .rst_n(core_rst_n),
         .start(dma_start[c]), .abort(dma_abort[c]), .cfg(dma_cfg[c]),
         .desc_in(desc_in[c]), .desc_valid(desc_valid[c]), .hs_tx(hs_tx),
         .hs_rx(hs_rx), .fifo_ok(fifo_ok[c]), .fifo_rdata(rx_head_w),
         .mem_ready(mem_ready[c]), .mem_req(mem_req[c]), .move(dma_move[c]),
         .desc_req(desc_req[c]), .desc_addr(desc_addr[c]), .done(dma_done[c]),
         .busy(dma_busy[c]));
   end

   // Serial engine, mode 0: clock idles low, data sampled on rising edge
   assign half = (ser_cfg.half_div < 8'(`MIN_HALF)) ? 8'(`MIN_HALF) : ser_cfg.half_div; // RULE2
   // Power gating stalls every edge so the pins cannot glitch mid-frame
   assign tick = (st_q != SER_IDLE) && (div_q >= half - 8'h01) && !power_gate; // RULE20
   assign tx_fpop = (st_q == SER_IDLE) && !tx_empty && !power_gate;
   assign frame_done = (st_q == SER_BITS) && tick && sclk_q && (bit_q == 5'h00);
   assign rx_fpush = frame_done && !rx_full; // RULE8

   always_comb begin
      st_d = st_q;
      div_d = tick ? 8'h00 : div_q + 8'h01;
      bit_d = bit_q;
      tx_sh_d = tx_sh_q;
      rx_sh_d = rx_sh_q;
      sclk_d = sclk_q;
      mosi_d = mosi_q;
      cs_b_d = cs_b_q;
      case (st_q)
         SER_IDLE: begin
            div_d = 8'h00;
            cs_b_d = 2'h3; // RULE24
            if (tx_fpop) begin
               tx_sh_d = tx_head & mask; // RULE5
               rx_sh_d = 32'h00000000; // RULE6
               bit_d = len;
               mosi_d = tx_head[len];
               cs_b_d = ser_cfg.cs_sel ? 2'h1 : 2'h2; // RULE10
               st_d = SER_LEAD;
            end
         end
         SER_LEAD: begin
            if (tick) begin
               sclk_d = 1'b1; // RULE1
               rx_sh_d = {rx_sh_q[30:0], miso_s_q}; // RULE8
               st_d = SER_BITS;
            end
         end
         SER_BITS: begin
            if (tick && sclk_q) begin
               sclk_d = 1'b0;
               if (bit_q == 5'h00) begin
                  st_d = SER_TRAIL;
               end else begin
                  bit_d = bit_q - 5'h01;
                  mosi_d = tx_sh_q[bit_q - 5'h01]; // RULE8
               end
            end else if (tick) begin
               sclk_d = 1'b1;
               rx_sh_d = {rx_sh_q[30:0], miso_s_q}; // RULE8
            end
         end
         SER_TRAIL: begin
            if (tick) begin
               cs_b_d = 2'h3; // RULE24
               mosi_d = 1'b0;
               st_d = SER_IDLE;
            end
         end
         default: st_d = SER_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!core_rst_n) begin
         st_q <= SER_IDLE;
         div_q <= '0;
         bit_q <= '0;
         tx_sh_q <= '0;
         rx_sh_q <= '0;
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
         cs_b_q <= 2'h3;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         bit_q <= bit_d;
         tx_sh_q <= tx_sh_d;
         rx_sh_q <= rx_sh_d;
         sclk_q <= sclk_d;
         mosi_q <= mosi_d;
         cs_b_q <= cs_b_d;
      end
   end
   assign sclk = sclk_q;
   assign cs_b = cs_b_q; // RULE23
   assign mosi = mosi_q;

   // Status: levels for thresholds, sticky bits where set beats clear
   always_comb begin
      st_set = '0;
      st_set[`ST_RX_OVR] = frame_done && rx_full; // RULE25
      st_set[`ST_TX_OVF] = tx_push && tx_full; // RULE25
      st_set[`ST_DMA0] = dma_done[0];
      st_set[`ST_DMA1] = dma_done[1];
      st_bits_d = (st_bits_q & ~stat_clr) | st_set; // RULE22
      st_bits_d[`ST_TX_LOW] = hs_tx; // RULE9
      st_bits_d[`ST_RX_HIGH] = hs_rx; // RULE9
      irq_d = |(st_bits_d & irq_en); // RULE22
      if (ltr_cfg.sw_mode) begin
         ltr_d = ltr_cfg.sw_val; // RULE21
      end else begin
         ltr_d = (st_q != SER_IDLE || !tx_empty || |dma_busy) ? ltr_cfg.act_val : 10'h000; // RULE21
      end
   end

   always_ff @(posedge clk) begin
      if (!core_rst_n) begin
         st_bits_q <= '0;
         irq_q <= 1'b0;
         ltr_q <= '0;
      end else begin
         st_bits_q <= st_bits_d;
         irq_q <= irq_d;
         ltr_q <= ltr_d;
      end
   end
   assign status = st_bits_q;
   assign irq = irq_q;
   assign ltr_val = ltr_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!core_rst_n);

   chk_cs_idle: assert property ((st_q == SER_IDLE) |-> (cs_b == 2'h3)) // RULE24
      else $error("chip select active outside a frame");
   chk_clk_in_frame: assert property (sclk |-> (cs_b != 2'h3)) // RULE1
      else $error("serial clock high without a selected peripheral");
   chk_bit_rate: assert property ($rose(sclk) |=> (!$rose(sclk)) [*8]) // RULE2
      else $error("serial clock faster than the top bit rate");
   chk_pg_freeze: assert property (power_gate && $past(power_gate) |->
      $stable(sclk) && $stable(cs_b) && $stable(mosi)) // RULE20
      else $error("serial pin moved during power gating");
   chk_rx_zero: assert property (rx_fpush |-> ((rx_sh_q & ~mask) == 32'h00000000)) // RULE6
      else $error("received word has bits above frame length");
   // Looks at the stored entry, so the frame length must not shrink while entries wait
   chk_tx_mask: assert property (tx_fpop |-> ((tx_head & ~mask) == 32'h00000000)) // RULE5
      else $error("transmit entry keeps bits above frame length");
   chk_cs_select: assert property ((st_q == SER_LEAD) && ($past(st_q) == SER_IDLE) |->
      cs_b == ($past(ser_cfg.cs_sel) ? 2'h1 : 2'h2)) // RULE10
      else $error("wrong chip select for the frame");
   chk_overrun_flag: assert property (frame_done && rx_full |=> status[`ST_RX_OVR] ##1 irq
      || !irq_en[`ST_RX_OVR] || $past(stat_clr[`ST_RX_OVR], 1)) // RULE25
      else $error("overrun not recorded");
   chk_irq_hold: assert property (status[`ST_TX_OVF] && irq_en[`ST_TX_OVF]
      && !stat_clr[`ST_TX_OVF] |=> irq && status[`ST_TX_OVF]) // RULE22
      else $error("interrupt dropped before the source was cleared");
endmodule // spi_master_with_dma

// ==== spi_peer_model.sv ====
// Behavioural serial peripheral that answers the master on the far side of the link
`timescale 1ns/1ps
module spi_peer_model (
   input wire logic sclk,
   input wire logic [1:0] cs_b,
   input wire logic mosi,
   input wire logic [31:0] reply,
   input wire logic [5:0] len,
   output logic miso,
   output logic [31:0] got,
   output logic [5:0] nbits
);
   logic [31:0] sh;
   logic sel;
   assign sel = (cs_b !== 2'h3);
   // The data-in line has a pull-down, so an unselected peer leaves it low
   assign miso = sel ? sh[31] : 1'b0;
   always @(posedge sel) begin
      sh = reply << (32 - len);
      got = 32'h0000_0000;
      nbits = 6'h00;
   end
   always @(posedge sclk) begin
      if (sel) begin
         got = {got[30:0], mosi};
         nbits = nbits + 6'h01;
      end
   end
   // Mode 0: the peer moves its data on the falling clock edge
   always @(negedge sclk) begin
      if (sel) sh = sh << 1;
   end
endmodule // spi_peer_model

// ==== testbench.sv ====
// Self-checking testbench for the serial port controller with DMA
`timescale 1ns/1ps
module testbench import spi_pkg::*;;
   typedef struct {
      logic [4:0] lm1;
      logic [7:0] hd;
      logic cs;
      logic [31:0] txd;
      logic [31:0] rep;
      logic [31:0] em;
      logic [31:0] er;
   } row_t;
   row_t rows[4] = '{
      '{5'h03, 8'h01, 1'b0, 32'hFFFF_FFFA, 32'h0000_0005, 32'h0000_000A, 32'h0000_0005},
      '{5'h07, 8'h06, 1'b1, 32'h1234_56C3, 32'hFFFF_FF3C, 32'h0000_00C3, 32'h0000_003C},
      '{5'h0F, 8'h05, 1'b0, 32'hDEAD_BEEF, 32'hFFFF_1234, 32'h0000_BEEF, 32'h0000_1234},
      '{5'h1F, 8'h09, 1'b1, 32'h8000_0001, 32'h7FFF_FFFE, 32'h8000_0001, 32'h7FFF_FFFE}};
   logic clk, rst_b, reset_wr, reset_val, power_gate, tx_push, tx_ready, rx_pop, rx_avail;
   logic irq, sclk, mosi, miso, we1;
   ser_cfg_t scfg;
   ltr_cfg_t lcfg;
   logic [9:0] ltr_val;
   logic [31:0] tx_data, rx_data, got, rep, w1;
   logic [1:0] dma_start, dma_abort, desc_valid, desc_req, mem_ready, dma_busy, cs_b, cs_seen;
   logic [1:0] sz0;
   dma_cfg_t [1:0] dcfg;
   dma_cfg_t [1:0] desc_in;
   logic [1:0][31:0] desc_addr;
   logic [1:0][31:0] mem_rdata;
   mem_req_t [1:0] mreq;
   logic [5:0] irq_en, stat_clr, status, nbits, plen;
   logic [7:0] hcnt, hlast;
   logic [31:0] a0[$];
   logic [31:0] a1[$];
   int fails, cmp_count;

   spi_master_with_dma u_dut (.clk(clk), .rst_b(rst_b), .reset_wr(reset_wr),
      .reset_val(reset_val), .power_gate(power_gate), .ser_cfg(scfg), .ltr_cfg(lcfg),
      .ltr_val(ltr_val), .tx_push(tx_push), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_pop(rx_pop), .rx_data(rx_data), .rx_avail(rx_avail), .dma_start(dma_start),
      .dma_abort(dma_abort), .dma_cfg(dcfg), .desc_in(desc_in), .desc_valid(desc_valid),
      .desc_req(desc_req), .desc_addr(desc_addr), .mem_req(mreq), .mem_ready(mem_ready),
      .mem_rdata(mem_rdata), .dma_busy(dma_busy), .irq_en(irq_en), .stat_clr(stat_clr),
      .status(status), .irq(irq), .sclk(sclk), .cs_b(cs_b), .mosi(mosi), .miso(miso));
   spi_peer_model u_peer (.sclk(sclk), .cs_b(cs_b), .mosi(mosi), .reply(rep), .len(plen),
      .miso(miso), .got(got), .nbits(nbits));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Memory answers one cycle late, so the request must stand until ready
   always @(posedge clk) begin
      for (int c = 0; c < 2; c++) begin
         mem_ready[c] <= mreq[c].valid && !mem_ready[c];
         mem_rdata[c] <= {16'hC0DE, mreq[c].addr[15:0]};
      end
      if (mreq[0].valid && mem_ready[0]) begin
         a0.push_back(mreq[0].addr);
         sz0 <= mreq[0].size;
      end
      if (mreq[1].valid && mem_ready[1]) begin
         a1.push_back(mreq[1].addr);
         w1 <= mreq[1].wdata;
         we1 <= mreq[1].we;
      end
   end
   always @(posedge clk) begin
      if (cs_b !== 2'h3) cs_seen <= cs_b;
      if (sclk === 1'b1) hcnt <= hcnt + 8'h01;
      else if (hcnt != 8'h00) begin
         hlast <= hcnt;
         hcnt <= 8'h00;
      end
   end

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic push(input logic [31:0] d);
      @(posedge clk);
      tx_push <= 1'b1;
      tx_data <= d;
      @(posedge clk);
      tx_push <= 1'b0;
   endtask
   task automatic run_core();
      @(posedge clk);
      reset_wr <= 1'b1;
      reset_val <= 1'b1;
      @(posedge clk);
      reset_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic frame();
      int k;
      k = 0;
      while (cs_b === 2'h3 && k < 400) begin
         @(negedge clk);
         k++;
      end
      repeat (2) @(negedge clk);
      chk("ltr_busy", {22'h0, ltr_val}, {22'h0, lcfg.act_val});
      while (cs_b !== 2'h3 && k < 4000) begin
         @(negedge clk);
         k++;
      end
      chk("frame_end", k < 4000, 1'b1);
      cyc(4);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      complete_run();
   end

   initial begin
      int k;
      rst_b = 1'b0;
      reset_wr = 1'b0;
      reset_val = 1'b0;
      power_gate = 1'b0;
      scfg = '{half_div:8'h05, len_m1:5'h07, cs_sel:1'b0, tx_thr:6'h04, rx_thr:6'h01};
      lcfg = '{sw_mode:1'b0, sw_val:10'h2AA, act_val:10'h155};
      tx_push = 1'b0;
      tx_data = 32'h0;
      rx_pop = 1'b0;
      dma_start = 2'h0;
      dma_abort = 2'h0;
      dcfg = '0;
      desc_in = '0;
      desc_valid = 2'h0;
      irq_en = 6'h00;
      stat_clr = 6'h00;
      rep = 32'h0;
      plen = 6'h08;
      hcnt = 8'h00;
      cyc(5);
      @(negedge clk);
      chk("rst_cs", cs_b, 2'h3);
      chk("rst_sclk", sclk, 1'b0);
      chk("rst_irq", irq, 1'b0);
      @(posedge clk) rst_b <= 1'b1;
      push(32'h0000_000F);
      cyc(40);
      @(negedge clk);
      chk("held_cs", cs_b, 2'h3);
      run_core();
      $display("test reset done");
      foreach (rows[i]) begin
         @(posedge clk);
         scfg.len_m1 <= rows[i].lm1;
         scfg.half_div <= rows[i].hd;
         scfg.cs_sel <= rows[i].cs;
         rep <= rows[i].rep;
         plen <= {1'b0, rows[i].lm1} + 6'h01;
         push(rows[i].txd);
         frame();
         @(negedge clk);
         chk("peer_word", got, rows[i].em);
         chk("peer_bits", nbits, plen);
         chk("rx_word", rx_data, rows[i].er);
         chk("rx_level", status[1], 1'b1);
         chk("cs_used", cs_seen, rows[i].cs ? 2'h1 : 2'h2);
         chk("half_bit", hlast, (rows[i].hd < 8'h05) ? 8'h05 : rows[i].hd);
         chk("ltr_idle", ltr_val, 10'h000);
         @(posedge clk) rx_pop <= 1'b1;
         @(posedge clk) rx_pop <= 1'b0;
         @(negedge clk);
         chk("rx_drained", rx_avail, 1'b0);
         $display("test frame %0d done", i);
      end
      // Engine frozen, so the FIFO fills and the extra write is refused
      @(posedge clk);
      power_gate <= 1'b1;
      irq_en <= 6'h08;
      lcfg.sw_mode <= 1'b1;
      scfg.len_m1 <= 5'h03;
      for (int i = 0; i < 64; i++) push(32'h5A5A_5A50 + i);
      @(negedge clk);
      chk("fifo_full", tx_ready, 1'b0);
      push(32'h0000_00FF);
      cyc(100);
      @(negedge clk);
      chk("ovf_flag", status[3], 1'b1);
      chk("irq_level", irq, 1'b1);
      chk("gate_cs", cs_b, 2'h3);
      chk("gate_sclk", sclk, 1'b0);
      chk("ltr_sw", ltr_val, 10'h2AA);
      chk("tx_level", status[0], 1'b0);
      @(posedge clk) stat_clr <= 6'h08;
      @(posedge clk) stat_clr <= 6'h00;
      cyc(2);
      @(negedge clk);
      chk("irq_clear", irq, 1'b0);
      $display("test overflow done");
      // Gate released: the 64 frozen entries plus one more overrun the receive FIFO
      @(posedge clk);
      power_gate <= 1'b0;
      irq_en <= 6'h04;
      scfg.half_div <= 8'h05;
      push(32'h0000_0003);
      cyc(3500);
      @(negedge clk);
      chk("ovr_flag", status[2], 1'b1);
      chk("ovr_irq", irq, 1'b1);
      $display("test overrun done");
      @(posedge clk);
      rst_b <= 1'b0;
      power_gate <= 1'b0;
      cyc(5);
      @(posedge clk) rst_b <= 1'b1;
      run_core();
      @(posedge clk);
      scfg.len_m1 <= 5'h1F;
      rep <= 32'h1357_9BDF;
      plen <= 6'h20;
      dcfg[0] <= '{src_addr:32'h0000_1000, block_bytes:12'h008, src_w:2'h2, dst_w:2'h2,
         src_inc:1'b1, default:'0};
      dcfg[1] <= '{dst_addr:32'h0000_2000, block_bytes:12'h008, src_w:2'h2, dst_w:2'h2,
         dst_inc:1'b1, hs_sel:1'b1, default:'0};
      @(posedge clk) dma_start <= 2'h3;
      @(posedge clk) dma_start <= 2'h0;
      cyc(2);
      k = 0;
      while (dma_busy !== 2'h0 && k < 4000) begin
         @(negedge clk);
         k++;
      end
      cyc(2);
      @(negedge clk);
      chk("dma_end", k < 4000, 1'b1);
      chk("dma_beats", a0.size(), 2);
      chk("src_a0", a0[0], 32'h0000_1000);
      chk("src_a1", a0[1], 32'h0000_1004);
      chk("src_size", sz0, 2'h2);
      chk("peer_dma", got, 32'hC0DE_1004);
      chk("dst_a1", a1[1], 32'h0000_2004);
      chk("dst_data", w1, 32'h1357_9BDF);
      chk("dst_we", we1, 1'b1);
      chk("dma_done", status[5:4], 2'h3);
      $display("test dma done");
      // An empty linked block goes straight to a descriptor fetch; abort ends the wait
      @(posedge clk);
      dcfg[0] <= '{link_en:1'b1, next_ptr:32'h0000_3000, default:'0};
      @(posedge clk) dma_start <= 2'h1;
      @(posedge clk) dma_start <= 2'h0;
      cyc(2);
      @(negedge clk);
      chk("desc_req", desc_req, 2'h1);
      chk("desc_addr", desc_addr[0], 32'h0000_3000);
      @(posedge clk) dma_abort <= 2'h1;
      @(posedge clk) dma_abort <= 2'h0;
      @(negedge clk);
      chk("abort_idle", dma_busy, 2'h0);
      $display("test descriptor done");
      complete_run();
   end
endmodule // testbench
